//--- sag_pkg.sv
package sag_pkg;

    // Reference kinds presented by the instruction context
    typedef enum logic [2:0] {
        SAG_REF_FETCH,
        SAG_REF_STACK,
        SAG_REF_STR_DST,
        SAG_REF_DATA,
        SAG_REF_IO_IMM,
        SAG_REF_IO_PORT
    } sag_ref_t;

    // Segment register numbering
    typedef enum logic [2:0] {
        SAG_SEG_DATA,
        SAG_SEG_CODE,
        SAG_SEG_STACK,
        SAG_SEG_EXTRA,
        SAG_SEG_F,
        SAG_SEG_G
    } sag_seg_t;

    // General register numbers of the base field
    localparam logic [2:0] SAG_GPR_STACK_PTR = 3'h4;
    localparam logic [2:0] SAG_GPR_FRAME_PTR = 3'h5;

    // Real mode selector shift and page geometry
    localparam int SAG_REAL_SHIFT = 4;
    localparam int SAG_PAGE_BITS = 12;
    localparam int SAG_SEG_COUNT = 6;

    // Values after reset
    localparam logic [31:0] SAG_ADDR_RST = 32'h0000_0000;
    localparam logic SAG_MIO_RST = 1'b1;

    // Reserved I/O window, kept clear by the system
    localparam logic [15:0] SAG_IO_RSVD_LO = 16'h00F8;
    localparam logic [15:0] SAG_IO_RSVD_HI = 16'h00FF;

endpackage

//--- sag_seg_sel.sv
`timescale 1ns/1ps
module sag_seg_sel (
    input wire sag_pkg::sag_ref_t ref_kind_i, // Reference kind
    input wire logic [2:0] base_gpr_i, // Base register number
    input wire logic ovr_valid_i, // Override prefix present
    input wire sag_pkg::sag_seg_t ovr_seg_i, // Override segment
    output sag_pkg::sag_seg_t seg_o // Chosen segment register
);
    import sag_pkg::*;

    // Default segment choice and override handling
    always_comb begin
        seg_o = SAG_SEG_DATA;
        case (ref_kind_i)
            SAG_REF_FETCH: seg_o = SAG_SEG_CODE;
            SAG_REF_STACK: seg_o = SAG_SEG_STACK;
            SAG_REF_STR_DST: seg_o = SAG_SEG_EXTRA;
            SAG_REF_DATA: begin
                if (ovr_valid_i) begin
                    seg_o = ovr_seg_i;
                end else if (base_gpr_i == SAG_GPR_FRAME_PTR || base_gpr_i == SAG_GPR_STACK_PTR) begin
                    seg_o = SAG_SEG_STACK;
                end else begin
                    seg_o = SAG_SEG_DATA;
                end
            end
            default: seg_o = SAG_SEG_DATA;
        endcase
    end
endmodule // sag_seg_sel

//--- sag_ea_calc.sv
`timescale 1ns/1ps
module sag_ea_calc (
    input wire logic [31:0] base_i, // Base register value
    input wire logic base_en_i, // Base in use
    input wire logic [31:0] index_i, // Index register value
    input wire logic index_en_i, // Index in use
    input wire logic [1:0] scale_i, // Scale code: 1,2,4,8
    input wire logic [31:0] disp_i, // Displacement, sign extended
    output logic [31:0] ea_o // Effective address
);
    // Scaled index sum, carry past bit 31 dropped
    always_comb begin
        logic [31:0] idx_scaled;
        idx_scaled = 32'h0000_0000;
        if (index_en_i) begin
            idx_scaled = index_i << scale_i;
        end
        ea_o = (base_en_i ? base_i : 32'h0000_0000) + idx_scaled + disp_i;
    end
endmodule // sag_ea_calc

//--- sag_addr_gen.sv
`timescale 1ns/1ps
module sag_addr_gen (
    input wire logic clock_i, // Processor clock
    input wire logic sys_rst_i, // Async reset, active high
    input wire logic clk_en_i, // Clock enable, freezes state when low
    input wire logic req_i, // Address request strobe
    input wire sag_pkg::sag_ref_t ref_kind_i, // Reference kind
    input wire logic prot_mode_i, // Protected mode when high
    input wire logic paging_en_i, // Paging enabled
    input wire logic [1:0] size_i, // Operand bytes minus one: 0,1,3
    input wire logic [31:0] ip_i, // Instruction pointer
    input wire logic [2:0] base_gpr_i, // Base register number
    input wire logic [31:0] base_i, // Base register value
    input wire logic base_en_i, // Base in use
    input wire logic [31:0] index_i, // Index register value
    input wire logic index_en_i, // Index in use
    input wire logic [1:0] scale_i, // Scale code
    input wire logic [31:0] disp_i, // Displacement
    input wire logic ovr_valid_i, // Override prefix present
    input wire sag_pkg::sag_seg_t ovr_seg_i, // Override segment
    input wire logic [15:0] code_segment_reg_i, // Code selector
    input wire logic [15:0] stack_segment_reg_i, // Stack selector
    input wire logic [15:0] data_segment_reg_i, // Data selector
    input wire logic [15:0] extra_segment_reg_i, // Extra selector
    input wire logic [15:0] f_segment_reg_i, // F selector
    input wire logic [15:0] g_segment_reg_i, // G selector
    input wire logic [31:0] code_base_i, // Code descriptor base
    input wire logic [31:0] stack_base_i, // Stack descriptor base
    input wire logic [31:0] data_base_i, // Data descriptor base
    input wire logic [31:0] extra_base_i, // Extra descriptor base
    input wire logic [31:0] f_base_i, // F descriptor base
    input wire logic [31:0] g_base_i, // G descriptor base
    input wire logic [7:0] io_imm_i, // Immediate port number
    input wire logic [15:0] port_addr_reg_i, // Port register value
    input wire logic [19:0] page_frame_i, // Translated page frame
    output logic addr_valid_o, // Address valid pulse
    output logic [31:0] linear_addr_o, // Linear address
    output logic [31:0] phys_addr_o, // Physical address
    output logic [3:0] byte_en_o, // Byte lanes from low address
    output logic mem_io_sel_o, // High memory, low I/O
    output sag_pkg::sag_seg_t seg_used_o, // Segment register used
    output logic [31:0] offset_o // Effective offset
);
    import sag_pkg::*;

    typedef struct packed {
        logic addr_valid;
        logic [31:0] linear_addr;
        logic [31:0] phys_addr;
        logic [3:0] byte_en;
        logic mem_io_sel;
        sag_seg_t seg_used;
        logic [31:0] offset;
    } sag_state_t;

    sag_state_t state_reg;
    sag_state_t state_next;
    sag_seg_t seg_sel;
    logic [31:0] ea;
    logic [15:0] sel_val;
    logic [31:0] seg_base;
    logic is_io;
    logic [31:0] ea_or_ip;

    // Default segment choice
    sag_seg_sel u_seg_sel (
        .ref_kind_i(ref_kind_i),
        .base_gpr_i(base_gpr_i),
        .ovr_valid_i(ovr_valid_i),
        .ovr_seg_i(ovr_seg_i),
        .seg_o(seg_sel)
    );

    // Effective address adder
    sag_ea_calc u_ea_calc (
        .base_i(base_i),
        .base_en_i(base_en_i),
        .index_i(index_i),
        .index_en_i(index_en_i),
        .scale_i(scale_i),
        .disp_i(disp_i),
        .ea_o(ea)
    );

    // Port accesses skip segmentation and paging
    assign is_io = (ref_kind_i == SAG_REF_IO_IMM) || (ref_kind_i == SAG_REF_IO_PORT);

    // Selector and descriptor base of the chosen segment; bases may overlap
    always_comb begin
        case (seg_sel)
            SAG_SEG_CODE: begin
                sel_val = code_segment_reg_i;
                seg_base = code_base_i;
            end
            SAG_SEG_STACK: begin
                sel_val = stack_segment_reg_i;
                seg_base = stack_base_i;
            end
            SAG_SEG_EXTRA: begin
                sel_val = extra_segment_reg_i;
                seg_base = extra_base_i;
            end
            SAG_SEG_F: begin
                sel_val = f_segment_reg_i;
                seg_base = f_base_i;
            end
            SAG_SEG_G: begin
                sel_val = g_segment_reg_i;
                seg_base = g_base_i;
            end
            default: begin
                sel_val = data_segment_reg_i;
                seg_base = data_base_i;
            end
        endcase
    end

    // Next state: offset, linear, physical, lanes and space select
    always_comb begin
        logic [31:0] off;
        logic [31:0] lin;
        state_next = state_reg;
        off = ea;
        lin = 32'h0000_0000;
        state_next.addr_valid = 1'b0;
        if (req_i) begin
            if (ref_kind_i == SAG_REF_FETCH) begin
                off = ip_i;
            end
            if (is_io) begin
                // Port number used as-is, zero extended
                if (ref_kind_i == SAG_REF_IO_IMM) begin
                    lin = {24'h00_0000, io_imm_i};
                end else begin
                    lin = {16'h0000, port_addr_reg_i};
                end
                state_next.phys_addr = lin;
                state_next.mem_io_sel = 1'b0;
            end else begin
                if (prot_mode_i) begin
                    lin = seg_base + off;
                end else begin
                    lin = ({16'h0000, sel_val} << SAG_REAL_SHIFT) + off;
                end
                if (paging_en_i) begin
                    state_next.phys_addr = {page_frame_i, lin[SAG_PAGE_BITS-1:0]};
                end else begin
                    state_next.phys_addr = lin;
                end
                state_next.mem_io_sel = 1'b1;
            end
            // Lanes counted up from the low-order byte address
            case (size_i)
                2'h0: state_next.byte_en = 4'h1;
                2'h1: state_next.byte_en = 4'h3;
                default: state_next.byte_en = 4'hF;
            endcase
            state_next.linear_addr = lin;
            state_next.offset = off;
            state_next.seg_used = seg_sel;
            state_next.addr_valid = 1'b1;
        end
    end

    // State register with clock enable
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= '{addr_valid: 1'b0, linear_addr: SAG_ADDR_RST, phys_addr: SAG_ADDR_RST,
                           byte_en: 4'h0, mem_io_sel: SAG_MIO_RST, seg_used: SAG_SEG_DATA,
                           offset: SAG_ADDR_RST};
        end else if (clk_en_i) begin
            state_reg <= state_next;
        end
    end

    // Every output is a field of the state register
    assign addr_valid_o = state_reg.addr_valid;
    assign linear_addr_o = state_reg.linear_addr;
    assign phys_addr_o = state_reg.phys_addr;
    assign byte_en_o = state_reg.byte_en;
    assign mem_io_sel_o = state_reg.mem_io_sel;
    assign seg_used_o = state_reg.seg_used;
    assign offset_o = state_reg.offset;

    // Offset the request actually uses, for the checks below
    assign ea_or_ip = (ref_kind_i == SAG_REF_FETCH) ? ip_i : ea;

    // Checks
    property p_io_low;
        @(posedge clock_i) disable iff (sys_rst_i)
        (clk_en_i && req_i && is_io) |=> (!mem_io_sel_o && addr_valid_o);
    endproperty
    a_io_low: assert property (p_io_low) else $error("I/O select not low");

    property p_mem_high;
        @(posedge clock_i) disable iff (sys_rst_i)
        (clk_en_i && req_i && !is_io) |=> mem_io_sel_o;
    endproperty
    a_mem_high: assert property (p_mem_high) else $error("Memory select not high");

    property p_io_zero_ext;
        @(posedge clock_i) disable iff (sys_rst_i)
        (addr_valid_o && !mem_io_sel_o) |-> (phys_addr_o[31:16] == 16'h0000 && phys_addr_o == linear_addr_o);
    endproperty
    a_io_zero_ext: assert property (p_io_zero_ext) else $error("Port address not zero extended");

    property p_real_lin;
        @(posedge clock_i) disable iff (sys_rst_i)
        (clk_en_i && req_i && !is_io && !prot_mode_i)
            |=> (linear_addr_o == ({16'h0000, $past(sel_val)} << 4) + $past(ea_or_ip));
    endproperty
    a_real_lin: assert property (p_real_lin) else $error("Real mode linear wrong");

    property p_prot_lin;
        @(posedge clock_i) disable iff (sys_rst_i)
        (clk_en_i && req_i && !is_io && prot_mode_i) |=> (linear_addr_o == $past(seg_base) + $past(ea_or_ip));
    endproperty
    a_prot_lin: assert property (p_prot_lin) else $error("Protected linear wrong");

    property p_no_paging;
        @(posedge clock_i) disable iff (sys_rst_i)
        (clk_en_i && req_i && !is_io && !paging_en_i) |=> (phys_addr_o == linear_addr_o);
    endproperty
    a_no_paging: assert property (p_no_paging) else $error("Physical differs from linear");

    property p_page_off;
        @(posedge clock_i) disable iff (sys_rst_i)
        addr_valid_o |-> (phys_addr_o[11:0] == linear_addr_o[11:0]);
    endproperty
    a_page_off: assert property (p_page_off) else $error("Page offset changed");

    property p_fetch_code;
        @(posedge clock_i) disable iff (sys_rst_i)
        (clk_en_i && req_i && ref_kind_i == SAG_REF_FETCH) |=> (seg_used_o == SAG_SEG_CODE && offset_o == $past(ip_i));
    endproperty
    a_fetch_code: assert property (p_fetch_code) else $error("Fetch not via code segment");

    property p_stack;
        @(posedge clock_i) disable iff (sys_rst_i)
        (clk_en_i && req_i && ref_kind_i == SAG_REF_STACK) |=> (seg_used_o == SAG_SEG_STACK);
    endproperty
    a_stack: assert property (p_stack) else $error("Stack not via stack segment");

    property p_str_dst;
        @(posedge clock_i) disable iff (sys_rst_i)
        (clk_en_i && req_i && ref_kind_i == SAG_REF_STR_DST) |=> (seg_used_o == SAG_SEG_EXTRA);
    endproperty
    a_str_dst: assert property (p_str_dst) else $error("String dest not via extra segment");

    property p_override;
        @(posedge clock_i) disable iff (sys_rst_i)
        (clk_en_i && req_i && ref_kind_i == SAG_REF_DATA && ovr_valid_i) |=> (seg_used_o == $past(ovr_seg_i));
    endproperty
    a_override: assert property (p_override) else $error("Override ignored");

    property p_dword_lanes;
        @(posedge clock_i) disable iff (sys_rst_i)
        (clk_en_i && req_i && size_i == 2'h3) |=> (byte_en_o == 4'hF && offset_o == $past(ea_or_ip));
    endproperty
    a_dword_lanes: assert property (p_dword_lanes) else $error("Dword lanes wrong");

    // Size code 2 is served as a doubleword
    property p_size_two;
        @(posedge clock_i) disable iff (sys_rst_i)
        (clk_en_i && req_i && size_i == 2'h2) |=> (byte_en_o == 4'hF);
    endproperty
    a_size_two: assert property (p_size_two) else $error("Size two lanes wrong");

    property p_word_lanes;
        @(posedge clock_i) disable iff (sys_rst_i)
        (clk_en_i && req_i && size_i == 2'h1) |=> (byte_en_o == 4'h3);
    endproperty
    a_word_lanes: assert property (p_word_lanes) else $error("Word lanes wrong");

    property p_low_lane;
        @(posedge clock_i) disable iff (sys_rst_i)
        addr_valid_o |-> byte_en_o[0];
    endproperty
    a_low_lane: assert property (p_low_lane) else $error("Addressed byte lane not enabled");

    property p_data_default;
        @(posedge clock_i) disable iff (sys_rst_i)
        (clk_en_i && req_i && ref_kind_i == SAG_REF_DATA && !ovr_valid_i && base_gpr_i != SAG_GPR_FRAME_PTR
            && base_gpr_i != SAG_GPR_STACK_PTR) |=> (seg_used_o == SAG_SEG_DATA);
    endproperty
    a_data_default: assert property (p_data_default) else $error("Data default not data segment");

    property p_frame_stack;
        @(posedge clock_i) disable iff (sys_rst_i)
        (clk_en_i && req_i && ref_kind_i == SAG_REF_DATA && !ovr_valid_i
            && (base_gpr_i == SAG_GPR_FRAME_PTR || base_gpr_i == SAG_GPR_STACK_PTR))
            |=> (seg_used_o == SAG_SEG_STACK);
    endproperty
    a_frame_stack: assert property (p_frame_stack) else $error("Pointer base not stack segment");

    property p_no_implicit_efg;
        @(posedge clock_i) disable iff (sys_rst_i)
        (clk_en_i && req_i && !is_io && ref_kind_i != SAG_REF_STR_DST
            && (ref_kind_i != SAG_REF_DATA || !ovr_valid_i))
            |=> (seg_used_o != SAG_SEG_EXTRA && seg_used_o != SAG_SEG_F && seg_used_o != SAG_SEG_G);
    endproperty
    a_no_implicit_efg: assert property (p_no_implicit_efg) else $error("Extra, F or G without override");

    property p_io_imm;
        @(posedge clock_i) disable iff (sys_rst_i)
        (clk_en_i && req_i && ref_kind_i == SAG_REF_IO_IMM) |=> (linear_addr_o == {24'h00_0000, $past(io_imm_i)});
    endproperty
    a_io_imm: assert property (p_io_imm) else $error("Immediate port address wrong");

    property p_io_port;
        @(posedge clock_i) disable iff (sys_rst_i)
        (clk_en_i && req_i && ref_kind_i == SAG_REF_IO_PORT)
            |=> (phys_addr_o == {16'h0000, $past(port_addr_reg_i)});
    endproperty
    a_io_port: assert property (p_io_port) else $error("Register port address wrong");

    property p_page_frame;
        @(posedge clock_i) disable iff (sys_rst_i)
        (clk_en_i && req_i && !is_io && paging_en_i) |=> (phys_addr_o[31:SAG_PAGE_BITS] == $past(page_frame_i));
    endproperty
    a_page_frame: assert property (p_page_frame) else $error("Page frame not applied");

    property p_ea_sum;
        @(posedge clock_i) disable iff (sys_rst_i)
        (clk_en_i && req_i && ref_kind_i == SAG_REF_DATA)
            |=> (offset_o == ($past(base_en_i) ? $past(base_i) : 32'h0000_0000)
                + ($past(index_en_i) ? ($past(index_i) << $past(scale_i)) : 32'h0000_0000) + $past(disp_i));
    endproperty
    a_ea_sum: assert property (p_ea_sum) else $error("Effective address wrong");

endmodule // sag_addr_gen

//--- sag_bus_model.sv
`timescale 1ns/1ps
module sag_bus_model
    import sag_pkg::*;
(
    input wire logic addr_valid_i, // Address strobe from the processor
    input wire logic mem_io_sel_i, // High memory, low I/O
    input wire logic [31:0] phys_addr_i, // Physical address
    output logic mem_sel_o, // Memory took the access
    output logic io_sel_o // A peripheral port answered
);
    // Memory takes every memory cycle, whatever its address; no address bit is decoded
    assign mem_sel_o = addr_valid_i & mem_io_sel_i;
    // Ports live in a 64K space and no peripheral sits in the reserved window
    assign io_sel_o = addr_valid_i & ~mem_io_sel_i & (phys_addr_i[31:16] == 16'h0000)
        & ~((phys_addr_i[15:0] >= SAG_IO_RSVD_LO) && (phys_addr_i[15:0] <= SAG_IO_RSVD_HI));
endmodule // sag_bus_model

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import sag_pkg::*;
    logic clock_i, sys_rst_i, clk_en_i, req_i, prot_mode_i, paging_en_i, base_en_i, index_en_i, ovr_valid_i;
    sag_ref_t ref_kind_i;
    sag_seg_t ovr_seg_i, seg_used_o;
    logic [1:0] size_i, scale_i;
    logic [2:0] base_gpr_i;
    logic [31:0] ip_i, base_i, index_i, disp_i, linear_addr_o, phys_addr_o, offset_o;
    logic [15:0] sel [6];
    logic [31:0] segb [6];
    logic [7:0] io_imm_i;
    logic [15:0] port_addr_reg_i;
    logic [19:0] page_frame_i;
    logic addr_valid_o, mem_io_sel_o, mem_sel, io_sel;
    logic [3:0] byte_en_o;
    int errors, n_tests;

    sag_addr_gen u_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .req_i(req_i),
        .ref_kind_i(ref_kind_i), .prot_mode_i(prot_mode_i), .paging_en_i(paging_en_i), .size_i(size_i),
        .ip_i(ip_i), .base_gpr_i(base_gpr_i), .base_i(base_i), .base_en_i(base_en_i), .index_i(index_i),
        .index_en_i(index_en_i), .scale_i(scale_i), .disp_i(disp_i), .ovr_valid_i(ovr_valid_i),
        .ovr_seg_i(ovr_seg_i), .code_segment_reg_i(sel[1]), .stack_segment_reg_i(sel[2]),
        .data_segment_reg_i(sel[0]), .extra_segment_reg_i(sel[3]), .f_segment_reg_i(sel[4]),
        .g_segment_reg_i(sel[5]), .code_base_i(segb[1]), .stack_base_i(segb[2]), .data_base_i(segb[0]),
        .extra_base_i(segb[3]), .f_base_i(segb[4]), .g_base_i(segb[5]), .io_imm_i(io_imm_i),
        .port_addr_reg_i(port_addr_reg_i), .page_frame_i(page_frame_i), .addr_valid_o(addr_valid_o),
        .linear_addr_o(linear_addr_o), .phys_addr_o(phys_addr_o), .byte_en_o(byte_en_o),
        .mem_io_sel_o(mem_io_sel_o), .seg_used_o(seg_used_o), .offset_o(offset_o));
    sag_bus_model u_bus (.addr_valid_i(addr_valid_o), .mem_io_sel_i(mem_io_sel_o), .phys_addr_i(phys_addr_o),
        .mem_sel_o(mem_sel), .io_sel_o(io_sel));

    // Clock of 100 ns period
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Expected linear address from segment number and offset
    function automatic logic [31:0] lin(input int s, input logic [31:0] off);
        return prot_mode_i ? segb[s] + off : ({16'h0000, sel[s]} << 4) + off;
    endfunction

    // Issue one request and check the one-cycle answer
    task automatic go();
        req_i <= 1'b1;
        @(posedge clock_i);
        req_i <= 1'b0;
        #1;
        chk("valid", 32'h1, {31'h0, addr_valid_o});
    endtask

    task automatic res(input sag_seg_t s, input logic [31:0] l, input logic [31:0] p, input logic [3:0] be,
        input logic m);
        chk("seg", {29'h0, s}, {29'h0, seg_used_o});
        chk("linear", l, linear_addr_o);
        chk("phys", p, phys_addr_o);
        chk("byte_en", {28'h0, be}, {28'h0, byte_en_o});
        chk("space", {31'h0, m}, {31'h0, mem_io_sel_o});
        chk("far side", 32'h1, {31'h0, m ? mem_sel : io_sel});
    endtask

    task automatic t_real_data();
        logic [1:0] sz [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
        logic [3:0] be [4] = '{4'h1, 4'h3, 4'hF, 4'hF};
        for (int i = 0; i < 4; i++) begin
            @(posedge clock_i);
            ref_kind_i <= SAG_REF_DATA; base_gpr_i <= 3'h3; base_i <= 32'h0000_0010; size_i <= sz[i];
            go();
            res(SAG_SEG_DATA, 32'h0001_0010, 32'h0001_0010, be[i], 1'b1);
        end
        $display("test real_data done");
    endtask

    task automatic t_default_seg();
        for (int g = 0; g < 8; g++) begin
            @(posedge clock_i);
            base_gpr_i <= 3'(g); base_i <= 32'h0000_1234; disp_i <= 32'hFFFF_FFFE;
            go();
            res((g == 4 || g == 5) ? SAG_SEG_STACK : SAG_SEG_DATA, lin((g == 4 || g == 5) ? 2 : 0, 32'h1232),
                lin((g == 4 || g == 5) ? 2 : 0, 32'h1232), 4'hF, 1'b1);
        end
        $display("test default_seg done");
    endtask

    task automatic t_override();
        for (int s = 0; s < 6; s++) begin
            @(posedge clock_i);
            base_gpr_i <= 3'h5; ovr_valid_i <= 1'b1; ovr_seg_i <= sag_seg_t'(s);
            go();
            res(sag_seg_t'(s), lin(s, 32'h1232), lin(s, 32'h1232), 4'hF, 1'b1);
        end
        $display("test override done");
    endtask

    task automatic t_fixed();
        sag_ref_t k [3] = '{SAG_REF_FETCH, SAG_REF_STACK, SAG_REF_STR_DST};
        sag_seg_t e [3] = '{SAG_SEG_CODE, SAG_SEG_STACK, SAG_SEG_EXTRA};
        for (int i = 0; i < 3; i++) begin
            @(posedge clock_i);
            ref_kind_i <= k[i]; ovr_seg_i <= SAG_SEG_G; ip_i <= 32'h0000_0100;
            go();
            res(e[i], lin(e[i], i == 0 ? 32'h100 : 32'h1232),
                lin(e[i], i == 0 ? 32'h100 : 32'h1232), 4'hF, 1'b1);
            chk("fixed linear", lin(e[i], i == 0 ? 32'h100 : 32'h1232), linear_addr_o);
        end
        $display("test fixed_seg done");
    endtask

    task automatic t_prot();
        logic [31:0] off;
        for (int s = 0; s < 4; s++) begin
            @(posedge clock_i);
            ref_kind_i <= SAG_REF_DATA; ovr_valid_i <= 1'b0; prot_mode_i <= 1'b1; base_gpr_i <= 3'h0;
            base_i <= 32'hFFFF_FFF0; index_en_i <= 1'b1; index_i <= 32'h3; scale_i <= 2'(s);
            disp_i <= 32'h20;
            go();
            off = 32'hFFFF_FFF0 + (32'h3 << s) + 32'h20;
            chk("offset", off, offset_o);
            res(SAG_SEG_DATA, segb[0] + off, segb[0] + off, 4'hF, 1'b1);
        end
        @(posedge clock_i);
        paging_en_i <= 1'b1; page_frame_i <= 20'hABCDE;
        go();
        res(SAG_SEG_DATA, segb[0] + off, {20'hABCDE, segb[0][11:0] + off[11:0]}, 4'hF, 1'b1);
        $display("test protected done");
    endtask

    task automatic t_io();
        @(posedge clock_i);
        ref_kind_i <= SAG_REF_IO_IMM; io_imm_i <= 8'h60; size_i <= 2'h0;
        go();
        res(SAG_SEG_DATA, 32'h0000_0060, 32'h0000_0060, 4'h1, 1'b0);
        @(posedge clock_i);
        ref_kind_i <= SAG_REF_IO_PORT; port_addr_reg_i <= 16'hFFFC; size_i <= 2'h3;
        go();
        res(SAG_SEG_DATA, 32'h0000_FFFC, 32'h0000_FFFC, 4'hF, 1'b0);
        $display("test io done");
    endtask

    task automatic t_b2b_freeze();
        @(posedge clock_i);
        ref_kind_i <= SAG_REF_DATA; prot_mode_i <= 1'b0; paging_en_i <= 1'b0; index_en_i <= 1'b0;
        disp_i <= 32'h0; base_i <= 32'h10; req_i <= 1'b1;
        @(posedge clock_i);
        base_i <= 32'h20;
        #1;
        chk("b2b first", 32'h0001_0010, linear_addr_o);
        @(posedge clock_i);
        req_i <= 1'b0;
        clk_en_i <= 1'b0;
        #1;
        chk("b2b second", 32'h0001_0020, linear_addr_o);
        chk("b2b valid", 32'h1, {31'h0, addr_valid_o});
        repeat (2) @(posedge clock_i);
        #1;
        chk("frozen valid", 32'h1, {31'h0, addr_valid_o});
        @(posedge clock_i);
        clk_en_i <= 1'b1;
        @(posedge clock_i);
        #1;
        chk("valid drop", 32'h0, {31'h0, addr_valid_o});
        $display("test b2b_freeze done");
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        errors = 0; n_tests = 0; sys_rst_i = 1'b1; clk_en_i = 1'b1; req_i = 1'b0; prot_mode_i = 1'b0;
        paging_en_i = 1'b0; base_en_i = 1'b1; index_en_i = 1'b0; ovr_valid_i = 1'b0; ref_kind_i = SAG_REF_DATA;
        ovr_seg_i = SAG_SEG_DATA; size_i = 2'h3; scale_i = 2'h0; base_gpr_i = 3'h3; ip_i = 32'h0;
        base_i = 32'h0; index_i = 32'h0; disp_i = 32'h0; io_imm_i = 8'h00; port_addr_reg_i = 16'h0000;
        page_frame_i = 20'h00000;
        sel = '{16'h1000, 16'h2100, 16'h3200, 16'h4300, 16'h5400, 16'h6500};
        segb = '{32'hF000_0000, 32'h0100_0000, 32'h0200_0000, 32'h0300_0000, 32'h0400_0000, 32'h0000_0000};
        repeat (3) @(posedge clock_i);
        #1;
        chk("reset space", 32'h1, {31'h0, mem_io_sel_o});
        chk("reset valid", 32'h0, {31'h0, addr_valid_o});
        chk("reset phys", 32'h0, phys_addr_o);
        @(posedge clock_i);
        sys_rst_i <= 1'b0;
        t_real_data();
        t_default_seg();
        t_override();
        t_fixed();
        t_prot();
        t_io();
        t_b2b_freeze();
        final_report();
    end
endmodule // tb_top
